/* File: design/apst_cfg.svh */
// Purpose: constants for the alternate pin strap and tone block
// Assumes: word-addressed avalon slave, 32-bit data
// Notes: offsets are word indices
`ifndef APST_CFG_SVH
`define APST_CFG_SVH
`define APST_IDX_SEL 3'h0
`define APST_IDX_DIR 3'h1
`define APST_IDX_IN 3'h2
`define APST_IDX_OUT 3'h3
`define APST_IDX_TINT 3'h4
`define APST_IDX_TENB 3'h5
`define APST_IDX_MODE 3'h6
`define APST_SEL_INPUT_MODE 16'hC00F
`define APST_SEL_NORMAL 16'h0000
`define APST_BIT_BUS_REQUEST 14
`define APST_BIT_DMA_REQUEST 15
`define APST_BIT_TONE 13
`define APST_BOOT_LAST 2'h2
`define APST_TONE_LOW 8'hFF
`define APST_TONE_ONE 16'h0001
`define APST_TONE_ZERO 16'h0000
`endif

/* File: design/apst_pkg.sv */
// Purpose: types for the alternate pin strap and tone block
// Assumes: nothing
// Notes: strap decode result
package apst_pkg;
  typedef enum logic [3:0] {
    APST_MODE_ALL_Z = 4'h1,
    APST_MODE_INPUT = 4'h2,
    APST_MODE_NORMAL = 4'h4,
    APST_MODE_TEST = 4'h8
  } apst_mode_t;
endpackage

/* File: design/apst_tone.sv */
// Purpose: tone counter driving the bus-grant pin level
// Assumes: one clock, counter steps every cycle
// Notes: level held while disabled
`timescale 1ns/1ps
`default_nettype none
`include "apst_cfg.svh"
module apst_tone (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] interval_in,
  input wire logic enable_in,
  output logic tone_level_out
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic level;
  logic next_level;
  always_comb begin
    next_count = count - `APST_TONE_ONE; // [R11]
    next_level = level;
    if (count == `APST_TONE_ZERO) begin
      next_count = {interval_in, `APST_TONE_LOW}; // [R5] [R6]
      if (enable_in) begin
        next_level = ~level; // [R7]
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= `APST_TONE_ZERO;
      level <= 1'b1;
    end else begin
      count <= next_count;
      level <= next_level;
    end
  end
  assign tone_level_out = level;
endmodule // apst_tone
`default_nettype wire

/* File: design/apst_top.sv */
// What this block does
// [R1] straps decode to all-outputs-off, input pin mode, normal mode or an unused test mode.
// [R2] input pin mode keeps address lines 22-25 off from reset and presets select bits 0-3 and 14-15.
// [R3] normal mode drives address lines 22-25 and clears the select register at reset.
// [R4] select bits 14 and 15 disable the bus-request and dma-request inputs.
// [R5] the 16-bit tone counter reloads its upper byte from the interval at zero.
// [R6] each reload puts all ones into the lower byte.
// [R7] with tone enabled and select bit 13 set the bus-grant pin toggles at each counter zero.
// [R8] software writes output values, then direction, then select.
// [R9] a direction bit of zero means input, one means output.
// [R10] sampled levels of address pins 22-25 read back from a status register.
// [R11] the tone counter steps down each clock and the pin holds while disabled.
//
// Purpose: alternate pin mux, strap decode and tone output
// Assumes: straps stable around reset release; avalon-mm slave, word addressed
// Notes: one wait state on every access once the straps are captured
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "apst_cfg.svh"
module apst_top
  import apst_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic float_strap_n_in,
  input wire logic test_strap_in,
  input wire logic [2:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [3:0] addr_hi_in,
  input wire logic [3:0] addr_hi_norm_in,
  output logic [3:0] addr_hi_out,
  output logic [3:0] addr_hi_oe_out,
  output logic all_outputs_off_out,
  input wire logic bus_request_in,
  input wire logic dma_request_in,
  output logic bus_request_out,
  output logic dma_request_out,
  input wire logic bus_grant_norm_in,
  output logic bus_grant_out,
  output logic [14:0] alt_output_value_out
);
  ////////////////////////////////////////////////////////////
  // strap and pin synchronisers
  logic [1:0] strap_s1;
  logic [1:0] strap_s2;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
      pin_s1 <= 6'h0;
      pin_s2 <= 6'h0;
    end else begin
      strap_s1 <= {float_strap_n_in, test_strap_in};
      strap_s2 <= strap_s1;
      pin_s1 <= {dma_request_in, bus_request_in, addr_hi_in};
      pin_s2 <= pin_s1;
    end
  end

  function automatic apst_mode_t decode_straps(input logic [1:0] s);
    case (s)
      2'h0: decode_straps = APST_MODE_ALL_Z;
      2'h1: decode_straps = APST_MODE_INPUT;
      2'h2: decode_straps = APST_MODE_NORMAL;
      default: decode_straps = APST_MODE_TEST;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////
  // mode capture: straps taken once, after the synchroniser fills
  apst_mode_t mode;
  apst_mode_t next_mode;
  logic [1:0] boot_cnt;
  logic [1:0] next_boot_cnt;
  logic booted;
  logic next_booted;
  logic [15:0] sel;
  logic [15:0] next_sel;
  logic [3:0] dir;
  logic [3:0] next_dir;
  logic [14:0] outv;
  logic [14:0] next_outv;
  logic [7:0] tint;
  logic [7:0] next_tint;
  logic tenb;
  logic next_tenb;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic waitreq;
  logic next_waitreq;
  logic req;
  always_comb begin
    req = avs_read_in | avs_write_in;
    next_mode = mode;
    next_boot_cnt = boot_cnt;
    next_booted = booted;
    next_sel = sel;
    next_dir = dir;
    next_outv = outv;
    next_tint = tint;
    next_tenb = tenb;
    next_rdata = rdata;
    next_waitreq = 1'b1;
    if (!booted) begin
      next_boot_cnt = boot_cnt + 2'h1;
      if (boot_cnt == `APST_BOOT_LAST) begin
        next_booted = 1'b1;
        next_mode = decode_straps(strap_s2); // [R1]
        if (decode_straps(strap_s2) == APST_MODE_INPUT) begin
          next_sel = `APST_SEL_INPUT_MODE; // [R2]
        end else begin
          next_sel = `APST_SEL_NORMAL; // [R3]
        end
      end
    end else if (req && waitreq) begin
      // answer one cycle after the request is seen
      next_waitreq = 1'b0;
      next_rdata = 32'h0;
      case (avs_address_in)
        `APST_IDX_SEL: next_rdata = {16'h0, sel};
        `APST_IDX_DIR: next_rdata = {28'h0, dir};
        `APST_IDX_IN: next_rdata = {28'h0, pin_s2[3:0]}; // [R10]
        `APST_IDX_OUT: next_rdata = {17'h0, outv};
        `APST_IDX_TINT: next_rdata = {24'h0, tint};
        `APST_IDX_TENB: next_rdata = {31'h0, tenb};
        `APST_IDX_MODE: next_rdata = {28'h0, mode};
        default: next_rdata = 32'h0;
      endcase
    end else if (avs_write_in && !waitreq) begin
      // commit on the edge the master sees waitrequest low, not earlier
      case (avs_address_in)
        `APST_IDX_SEL: next_sel = avs_writedata_in[15:0]; // [R8]
        `APST_IDX_DIR: next_dir = avs_writedata_in[3:0];
        `APST_IDX_OUT: next_outv = avs_writedata_in[14:0];
        `APST_IDX_TINT: next_tint = avs_writedata_in[7:0];
        `APST_IDX_TENB: next_tenb = avs_writedata_in[0];
        default: next_tenb = tenb;
      endcase
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode <= APST_MODE_ALL_Z;
      boot_cnt <= 2'h0;
      booted <= 1'b0;
      sel <= `APST_SEL_NORMAL;
      dir <= 4'h0;
      outv <= 15'h0;
      tint <= 8'h0;
      tenb <= 1'b0;
      rdata <= 32'h0;
      waitreq <= 1'b1;
    end else begin
      mode <= next_mode;
      boot_cnt <= next_boot_cnt;
      booted <= next_booted;
      sel <= next_sel;
      dir <= next_dir;
      outv <= next_outv;
      tint <= next_tint;
      tenb <= next_tenb;
      rdata <= next_rdata;
      waitreq <= next_waitreq;
    end
  end

  ////////////////////////////////////////////////////////////
  // tone generator
  logic tone_level;
  apst_tone u_tone (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .interval_in(tint),
    .enable_in(tenb),
    .tone_level_out(tone_level)
  );

  ////////////////////////////////////////////////////////////
  // pin muxing, registered so every output comes from a flop
  logic [3:0] next_a_out;
  logic [3:0] next_a_oe;
  logic next_off;
  logic next_bus_req;
  logic next_dma_req;
  logic next_grant;
  always_comb begin
    next_off = (mode == APST_MODE_ALL_Z) || !booted;
    next_a_out = addr_hi_norm_in;
    next_a_oe = 4'hF; // [R3]
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        next_a_out[i] = outv[i];
        next_a_oe[i] = dir[i]; // [R9]
      end
    end
    // off until straps are known, so input-mode pins never contend
    if (next_off) begin
      next_a_oe = 4'h0; // [R1] [R2]
    end
    next_bus_req = sel[`APST_BIT_BUS_REQUEST] ? 1'b0 : pin_s2[4]; // [R4]
    next_dma_req = sel[`APST_BIT_DMA_REQUEST] ? 1'b0 : pin_s2[5]; // [R4]
    next_grant = sel[`APST_BIT_TONE] ? tone_level : bus_grant_norm_in;
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_hi_out <= 4'h0;
      addr_hi_oe_out <= 4'h0;
      all_outputs_off_out <= 1'b1;
      bus_request_out <= 1'b0;
      dma_request_out <= 1'b0;
      bus_grant_out <= 1'b1;
    end else begin
      addr_hi_out <= next_a_out;
      addr_hi_oe_out <= next_a_oe;
      all_outputs_off_out <= next_off;
      bus_request_out <= next_bus_req;
      dma_request_out <= next_dma_req;
      bus_grant_out <= next_grant;
    end
  end
  assign avs_readdata_out = rdata;
  assign avs_waitrequest_out = waitreq;
  assign alt_output_value_out = outv;
endmodule // apst_top
`default_nettype wire

/* File: tb/apst_top_properties.sv */
// Purpose: port checker for apst_top
// Assumes: straps change only in reset, grant level input held high
// Notes: bound to apst_top below
`timescale 1ns/1ps
`default_nettype none
module apst_chk (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic float_strap_n_in,
  input wire logic test_strap_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic [3:0] addr_hi_oe_out,
  input wire logic all_outputs_off_out,
  input wire logic bus_request_out,
  input wire logic dma_request_out,
  input wire logic bus_grant_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  logic prev_grant, next_prev_grant;
  logic [15:0] gap, next_gap;
  always_comb begin
    next_prev_grant = bus_grant_out;
    next_gap = (bus_grant_out != prev_grant) ? 16'h0000 : gap + {15'h0000, ~&gap};
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev_grant <= 1'b1;
      gap <= 16'h0000;
    end else begin
      prev_grant <= next_prev_grant;
      gap <= next_gap;
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_off; (!float_strap_n_in && !test_strap_in) [*4] |=> all_outputs_off_out; endproperty
  a_off: assert property (p_off) else $error("outputs not off");
  property p_on; float_strap_n_in [*6] |=> !all_outputs_off_out; endproperty
  a_on: assert property (p_on) else $error("outputs still off");
  property p_inz; $rose(rstn_in) && test_strap_in && !float_strap_n_in |-> (addr_hi_oe_out == 4'h0) [*6]; endproperty
  a_inz: assert property (p_inz) else $error("high address driven");
  property p_drv; $rose(rstn_in) && float_strap_n_in && !test_strap_in |-> ##6 addr_hi_oe_out == 4'hF; endproperty
  a_drv: assert property (p_drv) else $error("high address not driven");
  property p_req; test_strap_in && !float_strap_n_in && !all_outputs_off_out |-> !bus_request_out && !dma_request_out; endproperty
  a_req: assert property (p_req) else $error("request input not blocked");
  // tone toggles are a whole reload period apart, 256 cycles at least
  property p_tone; bus_grant_out != prev_grant |-> gap >= 16'h00FF; endproperty
  a_tone: assert property (p_tone) else $error("grant toggled too soon");
  property p_ans; (avs_read_in || avs_write_in) && avs_waitrequest_out && !all_outputs_off_out |=> !avs_waitrequest_out; endproperty
  a_ans: assert property (p_ans) else $error("no bus answer");
  property p_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  a_one: assert property (p_one) else $error("answer too long");
endmodule // apst_chk
bind apst_top apst_chk u_chk (.*);
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for apst_top
// Assumes: straps change only in reset
// Notes: register model in mdl, masks in msk
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk_in, rstn_in, float_strap_n_in, test_strap_in, avs_read_in, avs_write_in;
  logic avs_waitrequest_out, all_outputs_off_out, bus_request_in, dma_request_in;
  logic bus_request_out, dma_request_out, bus_grant_norm_in, bus_grant_out;
  logic [2:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [3:0] addr_hi_in, addr_hi_norm_in, addr_hi_out, addr_hi_oe_out;
  logic [14:0] alt_output_value_out;
  int err_count, cmp_count, cyc, t0, iv;
  int mdl[8];
  int msk[8] = '{32'hFFFF, 32'hF, 0, 32'h7FFF, 32'hFF, 1, 0, 0};
  apst_top uut (.*);
  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, s, e);
    end
  endtask
  // read-only and unmapped places keep the model value
  task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (w) mdl[a] = mdl[a] & ~msk[a] | d & msk[a];
    else chk(q, mdl[a]);
  endtask
  task automatic boot(input logic f, input logic t);
    rstn_in <= 1'b0;
    float_strap_n_in <= f;
    test_strap_in <= t;
    repeat (10) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    mdl = '{default: 0};
    mdl[0] = (!f && t) ? 32'hC00F : 0;
    mdl[2] = addr_hi_in;
    mdl[6] = f ? (t ? 8 : 4) : (t ? 2 : 1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {rstn_in, avs_read_in, avs_write_in, bus_request_in, dma_request_in} = 5'h00;
    {avs_address_in, avs_writedata_in} = 35'h0;
    bus_grant_norm_in = 1'b1;
    void'($urandom(32'h7CF7));
    addr_hi_in = 4'($urandom);
    addr_hi_norm_in = 4'($urandom);
    for (int m = 0; m < 4; m++) begin
      boot(m[1], m[0]);
      chk(all_outputs_off_out, m == 0);
      chk(addr_hi_oe_out, m[1] ? 15 : 0);
      chk(addr_hi_out, (m == 1) ? 4'h0 : addr_hi_norm_in);
      for (int a = 0; a < 8; a++) acc(1'b0, 3'(a), 0);
      bus_request_in <= 1'b1;
      dma_request_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      if (m > 0) chk({bus_request_out, dma_request_out}, {2{m[1]}});
      bus_request_in <= 1'b0;
      dma_request_in <= 1'b0;
      if (m == 1) begin
        acc(1'b1, 3'h3, $urandom);
        acc(1'b1, 3'h1, $urandom);
        acc(1'b1, 3'h0, 32'hC00F);
        repeat (3) @(posedge core_clk_in);
        chk(addr_hi_oe_out, mdl[1]);
        chk(alt_output_value_out, mdl[3]);
        chk(addr_hi_out & addr_hi_oe_out, mdl[3] & mdl[1]);
      end
      if (m == 2) begin
        for (int a = 0; a < 8; a++) acc(1'b1, 3'(a), $urandom);
        for (int a = 0; a < 8; a++) acc(1'b0, 3'(a), 0);
      end
      if (m == 3) begin
        iv = $urandom_range(2);
        acc(1'b1, 3'h4, iv);
        acc(1'b1, 3'h0, 32'h2000);
        acc(1'b1, 3'h5, 1);
        @(bus_grant_out);
        t0 = cyc;
        @(bus_grant_out);
        chk(cyc - t0, (iv + 1) * 256);
        acc(1'b1, 3'h5, 0);
        // a zero on the commit edge still toggles once; let it reach the pin
        repeat (3) @(posedge core_clk_in);
        iv = bus_grant_out;
        repeat (800) @(posedge core_clk_in);
        chk(bus_grant_out, iv);
      end
    end
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
